// ==== hdl/rail_fault_pg_mask_regs.sv ====
/*
  Rail fault status, power-good mask and converter control register bank.
  Holds the fault flags, the masks and the converter control byte, builds
  the combined power-good level and drives the converter's control levels.
  Assumes an upstream serial management slave presents one byte access
  per reg_write pulse on clk; rail inputs and the sleep level are
  asynchronous and are synchronised here.
  A loss or power-good dip shorter than one clock period may be missed by
  the synchronisers; the analog side is expected to stretch it.
*/
`timescale 1ns/1ns
`default_nettype none
module rail_fault_pg_mask_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  output logic      [7:0]  reg_rdata,
  input  wire logic [9:0]  regulation_lost,
  input  wire logic [11:0] rail_pg,
  input  wire logic        sleep_state_signal,
  output logic             combined_power_good,
  output logic             fault_any,
  output logic      [1:0]  converter_mode,
  output logic             converter_enable,
  output logic             forced_pwm,
  output logic      [1:0]  output_voltage_select,
  output logic      [9:0]  output_voltage_mv,
  output logic             decay_active
);

  // Maps a voltage select code to its output level in millivolts.
  function automatic logic [9:0] level_mv(input logic [1:0] sel);
    logic [9:0] mv;
    mv = rail_pkg::LEVEL_0_MV;
    unique case (sel)
      2'h0: mv = rail_pkg::LEVEL_0_MV;
      2'h1: mv = rail_pkg::LEVEL_1_MV;
      2'h2: mv = rail_pkg::LEVEL_2_MV;
      2'h3: mv = rail_pkg::LEVEL_3_MV;
    endcase
    return mv;
  endfunction

  // True when a mode code runs the converter at all.
  function automatic logic mode_runs(input logic [1:0] mode);
    return mode != rail_pkg::MODE_OFF;
  endfunction

  // Synchronised copies of the asynchronous inputs.
  logic [9:0]  lost_sync;
  logic [11:0] pg_sync;
  logic        sleep_sync;

  // Register state.
  logic [7:0] mask_a_q;
  logic [7:0] mask_a_d;
  logic [3:0] mask_b_q;
  logic [3:0] mask_b_d;
  logic [6:0] conv_q;
  logic [6:0] conv_d;
  logic       sleep_prev_q;

  // Registered outputs and their next values.
  logic [7:0] rdata_d;
  logic       pg_d;
  logic       decay_d;

  // Decoded access strobes.
  wire logic hit_fault_a;
  wire logic hit_fault_b;
  wire logic hit_mask_a;
  wire logic hit_mask_b;
  wire logic hit_conv;
  wire logic wr_fault_a;
  wire logic wr_fault_b;
  wire logic wr_mask_a;
  wire logic wr_mask_b;
  wire logic wr_conv;

  // Converter fields and sleep events.
  wire logic [1:0]  mode_field;
  wire logic [1:0]  exit_field;
  wire logic [1:0]  vsel_field;
  wire logic        decay_en;
  wire logic        sleep_rise;
  wire logic [6:0]  conv_written;
  wire logic [11:0] pg_masked;
  logic      [11:0] pg_raw;

  // Next values of the converter status and fault summary outputs.
  wire logic        enable_d;
  wire logic        fpwm_d;
  wire logic [9:0]  level_d;
  wire logic        any_fault_d;

  fault_latch_if fault_bus ();

  // The sleep level resets high so a high level at release is no edge.
  input_sync #(
    .WIDTH       (1),
    .RESET_VALUE (1'b1)
  ) u_sleep_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (sleep_state_signal),
    .sync_out (sleep_sync)
  );

  // Loss levels reset low, so no rail reads as faulted before it is seen.
  input_sync #(
    .WIDTH       (10),
    .RESET_VALUE (10'h000)
  ) u_lost_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (regulation_lost),
    .sync_out (lost_sync)
  );

  // Power-good levels reset low, so the tree reads not-good until seen.
  input_sync #(
    .WIDTH       (12),
    .RESET_VALUE (12'h000)
  ) u_pg_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (rail_pg),
    .sync_out (pg_sync)
  );

  // The latch owns the sticky flags; this module only feeds and reads them.
  fault_latch u_fault_latch (
    .clk  (clk),
    .rst  (rst),
    .port (fault_bus.latch)
  );

  // One compare per register, shared by the read mux and the write strobes.
  // register offset decode
  assign hit_fault_a = reg_addr == rail_pkg::OFS_FAULT_A;
  assign hit_fault_b = reg_addr == rail_pkg::OFS_FAULT_B;
  assign hit_mask_a  = reg_addr == rail_pkg::OFS_MASK_A;
  assign hit_mask_b  = reg_addr == rail_pkg::OFS_MASK_B;
  assign hit_conv    = reg_addr == rail_pkg::OFS_CONV;

  // Write strobes qualified by the access pulse.
  assign wr_fault_a = reg_write & hit_fault_a;
  assign wr_fault_b = reg_write & hit_fault_b;
  assign wr_mask_a  = reg_write & hit_mask_a;
  assign wr_mask_b  = reg_write & hit_mask_b;
  assign wr_conv    = reg_write & hit_conv;

  // loss reaches latch
  // The flags follow the order of the two status bytes, A in the low bits.
  assign fault_bus.event_level = lost_sync;

  // write zero clears
  // A written 1 leaves the flag alone; only zeros clear.
  // A clear that meets a live loss on the same rail loses; the flag stays.
  assign fault_bus.clear_mask = {
    {2{wr_fault_b}} & ~reg_wdata[1:0],
    {8{wr_fault_a}} & ~reg_wdata
  };

  // Mask registers: only the implemented bits take write data.
  // Mask A has no reserved bits, so it takes the whole byte.
  assign mask_a_d = wr_mask_a ? reg_wdata : mask_a_q;
  assign mask_b_d = wr_mask_b ? reg_wdata[3:0] : mask_b_q;

  // Converter fields as they stand.
  assign mode_field = conv_q[rail_pkg::CONV_MODE_LSB +: 2];
  assign exit_field = conv_q[rail_pkg::CONV_EXIT_LSB +: 2];
  assign vsel_field = conv_q[rail_pkg::CONV_VSEL_LSB +: 2];
  assign decay_en   = conv_q[rail_pkg::CONV_DECAY_BIT];

  // Leaving standby is the low-to-high edge of the synchronised sleep level.
  // Its flop resets high like the idle pin, so reset makes no false edge.
  assign sleep_rise = sleep_sync & ~sleep_prev_q;

  assign conv_written = wr_conv ? reg_wdata[6:0] : conv_q;

  // exit mode copy
  // The hardware copy wins over a software write in the same cycle, so a
  // standby exit is never lost; the other fields still take the write.
  // An exit code of zero keeps whatever mode software left behind.
  always_comb begin
    conv_d = conv_written;
    if (sleep_rise && exit_field != rail_pkg::EXIT_NONE) begin
      conv_d[rail_pkg::CONV_MODE_LSB +: 2] = exit_field;
    end
  end

  // pg held in decay
  // During decay the converter's own rail is counted good while it sags.
  always_comb begin
    pg_raw = pg_sync;
    if (decay_d) begin
      pg_raw[rail_pkg::IO_RAIL_PG_BIT] = 1'b1;
    end
  end

  // A set mask bit lifts its rail, so it no longer affects the tree.
  // mask forces high
  assign pg_masked = pg_raw | {mask_b_q, mask_a_q};

  // One failing unmasked rail pulls the whole tree low.
  // AND of tree
  assign pg_d = &pg_masked;

  // Decay needs a running converter; with the mode off nothing can sag.
  // decay while asleep
  assign decay_d = decay_en & ~sleep_sync & mode_runs(mode_field);

  // mode decode
  // Converter status is decoded once here and registered below.
  assign enable_d    = mode_runs(mode_field);
  assign fpwm_d      = mode_field == rail_pkg::MODE_FPWM;
  assign level_d     = level_mv(vsel_field);

  // Summary of all flags; it trails the flags by one edge.
  assign any_fault_d = |fault_bus.flags;

  // reserved read zero
  // Unmapped offsets also read zero.
  // The address is decoded a cycle ahead, so data shows one edge later.
  always_comb begin
    rdata_d = 8'h00;
    if (hit_fault_a) begin
      rdata_d = fault_bus.flags[7:0];
    end else if (hit_fault_b) begin
      rdata_d = {6'h00, fault_bus.flags[9:8]};
    end else if (hit_mask_a) begin
      rdata_d = mask_a_q;
    end else if (hit_mask_b) begin
      rdata_d = {4'h0, mask_b_q};
    end else if (hit_conv) begin
      rdata_d = {1'b0, conv_q};
    end
  end

  // Register state, reset to the package's reset values.
  // The edge flop follows the synchronised level, never the pin itself.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_a_q     <= rail_pkg::RST_MASK_A;
      mask_b_q     <= rail_pkg::RST_MASK_B;
      conv_q       <= rail_pkg::RST_CONV;
      sleep_prev_q <= 1'b1;
    end else begin
      mask_a_q     <= mask_a_d;
      mask_b_q     <= mask_b_d;
      conv_q       <= conv_d;
      sleep_prev_q <= sleep_sync;
    end
  end

  // Read data and power-good outputs, one cycle behind their sources.
  // Power-good starts low and rises once the synchronised rails agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata           <= 8'h00;
      combined_power_good <= 1'b0;
      fault_any           <= 1'b0;
    end else begin
      reg_rdata           <= rdata_d;
      combined_power_good <= pg_d;
      fault_any           <= any_fault_d;
    end
  end

  // level select
  // Outputs track the stored fields; they lag the register by one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_mode        <= rail_pkg::RST_CONV[1:0];
      // Enable and forced flag agree with the reset mode from the start.
      converter_enable      <= rail_pkg::RST_CONV[1:0] != rail_pkg::MODE_OFF;
      forced_pwm            <= rail_pkg::RST_CONV[1:0] == rail_pkg::MODE_FPWM;
      output_voltage_select <= 2'h0;
      output_voltage_mv     <= rail_pkg::LEVEL_0_MV;
      decay_active          <= 1'b0;
    end else begin
      converter_mode        <= mode_field;
      converter_enable      <= enable_d;
      forced_pwm            <= fpwm_d;
      output_voltage_select <= vsel_field;
      output_voltage_mv     <= level_d;
      decay_active          <= decay_d;
    end
  end

endmodule // rail_fault_pg_mask_regs
`default_nettype wire

// ==== common/rail_pkg.sv ====
/*
  Constants for the rail fault, power-good mask and converter control bank:
  register offsets, reset values, field positions and level codes.
  Assumes an 8-bit register port with byte offsets as its address.

  // Function
  // - A rail losing regulation sets its fault flag.
  // - Writing 0 to a fault bit clears that flag.
  // - Fault status A at 0x16, resets zero, eight rail flags.
  // - Fault status B at 0x17, flags in bits 1:0, 7:2 reserved.
  // - Reserved bits are read-only, read zero, ignore writes.
  // - Mask bit 0 passes the rail's real power-good into the tree.
  // - Mask bit 1 forces the rail's power-good contribution high.
  // - Power-good mask A at 0x18, resets zero, one bit per rail.
  // - Power-good mask B at 0x19, bits 3:0 writable, 7:4 reserved.
  // - Converter control at 0x30, resets 0x0a, bit 7 reserved.
  // - Mode 00 off, 01/10 automatic, 11 forced pulse-width.
  // - Sleep rising edge copies non-zero exit mode into mode.
  // - Voltage select picks 0.975, 0.950, 0.875 or 0.850 volts.
  // - Decay enable lets output decay in sleep, power-good held.
*/
package rail_pkg;

  // Counts of rails seen by the fault flags and by the mask bits.
  localparam int unsigned NUM_FAULT = 10;
  localparam int unsigned NUM_PG    = 12;

  // Register offsets.
  localparam logic [7:0] OFS_FAULT_A = 8'h16;
  localparam logic [7:0] OFS_FAULT_B = 8'h17;
  localparam logic [7:0] OFS_MASK_A  = 8'h18;
  localparam logic [7:0] OFS_MASK_B  = 8'h19;
  localparam logic [7:0] OFS_CONV    = 8'h30;

  // Reset values.
  localparam logic [7:0] RST_FAULT_A = 8'h00;
  localparam logic [1:0] RST_FAULT_B = 2'h0;
  localparam logic [7:0] RST_MASK_A  = 8'h00;
  localparam logic [3:0] RST_MASK_B  = 4'h0;
  localparam logic [6:0] RST_CONV    = 7'h0a;

  // Converter control field positions.
  localparam int unsigned CONV_MODE_LSB  = 0;
  localparam int unsigned CONV_EXIT_LSB  = 2;
  localparam int unsigned CONV_VSEL_LSB  = 4;
  localparam int unsigned CONV_DECAY_BIT = 6;

  // Power-good mask bit of the converter's own rail.
  localparam int unsigned IO_RAIL_PG_BIT = 7;

  // Converter mode codes.
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_FPWM  = 2'h3;
  localparam logic [1:0] EXIT_NONE  = 2'h0;

  // Output levels in millivolts: 975, 950, 875 and 850.
  localparam logic [9:0] LEVEL_0_MV = 10'h3cf;
  localparam logic [9:0] LEVEL_1_MV = 10'h3b6;
  localparam logic [9:0] LEVEL_2_MV = 10'h36b;
  localparam logic [9:0] LEVEL_3_MV = 10'h352;

endpackage : rail_pkg

// ==== common/fault_latch_if.sv ====
/*
  Carrier between the register bank and its fault flag latch.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface fault_latch_if;
  logic [rail_pkg::NUM_FAULT-1:0] event_level;
  logic [rail_pkg::NUM_FAULT-1:0] clear_mask;
  logic [rail_pkg::NUM_FAULT-1:0] flags;

  modport bank  (output event_level, output clear_mask, input flags);
  modport latch (input event_level, input clear_mask, output flags);
endinterface : fault_latch_if
`default_nettype wire

// ==== hdl/input_sync.sv ====
/*
  Two-flop synchroniser for a bus of independent levels.
  Assumes each bit is a slow level; multi-bit values are not kept coherent.
*/
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
  parameter int unsigned         WIDTH       = 1,
  parameter logic [WIDTH-1:0]    RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // input_sync
`default_nettype wire

// ==== hdl/fault_latch.sv ====
/*
  Sticky rail fault flags.
  Assumes event levels are already synchronised to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fault_latch (
  input  wire logic   clk,
  input  wire logic   rst,
  fault_latch_if.latch port
);
  logic [rail_pkg::NUM_FAULT-1:0] flags_q;
  logic [rail_pkg::NUM_FAULT-1:0] flags_d;

  // set on loss
  // A set in the same cycle as a clear wins, so no loss event is dropped.
  assign flags_d = (flags_q & ~port.clear_mask) | port.event_level;
  assign port.flags = flags_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule // fault_latch
`default_nettype wire

// ==== sim/rail_fault_pg_mask_regs_assertions.sv ====
/*
  Port checker for the rail fault and power-good mask bank.
  Assumes rail_pkg is compiled first; bound to the top module below.
*/
`timescale 1ns/1ns
`default_nettype none
module rail_fault_pg_mask_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_rdata,
  input wire logic [9:0]  regulation_lost,
  input wire logic [11:0] rail_pg,
  input wire logic        combined_power_good,
  input wire logic        fault_any,
  input wire logic [1:0]  converter_mode,
  input wire logic        converter_enable,
  input wire logic        forced_pwm,
  input wire logic [1:0]  output_voltage_select,
  input wire logic [9:0]  output_voltage_mv,
  input wire logic        decay_active
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_enable_mode: assert property (
    converter_enable == (converter_mode != 2'h0))
    else $error("converter enable does not follow mode");
  a_forced_pwm: assert property (
    forced_pwm == (converter_mode == 2'h3))
    else $error("forced pwm does not follow mode");
  a_level_map: assert property (
    output_voltage_mv == (output_voltage_select == 2'h0 ?
      rail_pkg::LEVEL_0_MV : output_voltage_select == 2'h1 ?
      rail_pkg::LEVEL_1_MV : output_voltage_select == 2'h2 ?
      rail_pkg::LEVEL_2_MV : rail_pkg::LEVEL_3_MV))
    else $error("output level does not match select");
  a_decay_mode: assert property (
    decay_active |-> converter_enable)
    else $error("decay active with converter off");
  // The summary may only fall after a write reached the flags one cycle earlier.
  a_fault_hold: assert property (
    fault_any && !$past(reg_write) |=> fault_any)
    else $error("fault summary fell without a write");
  a_mask_readback: assert property (
    (reg_write && reg_addr == rail_pkg::OFS_MASK_A) ##1
    (!reg_write && reg_addr == rail_pkg::OFS_MASK_A)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mask write not read back");
  a_reserved_zero: assert property (
    reg_addr == rail_pkg::OFS_FAULT_B |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved status bits read non-zero");
  a_pg_all_good: assert property (
    (rail_pg == 12'hfff) [*5] |-> combined_power_good)
    else $error("power good low with all rails good");
  a_fault_from_loss: assert property (
    (regulation_lost != 10'h000) [*5] |-> fault_any)
    else $error("lost regulation not flagged");
endmodule // rail_fault_pg_mask_regs_checker

bind rail_fault_pg_mask_regs rail_fault_pg_mask_regs_checker u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_rdata(reg_rdata),
  .regulation_lost(regulation_lost), .rail_pg(rail_pg),
  .combined_power_good(combined_power_good), .fault_any(fault_any),
  .converter_mode(converter_mode), .converter_enable(converter_enable),
  .forced_pwm(forced_pwm), .output_voltage_select(output_voltage_select),
  .output_voltage_mv(output_voltage_mv), .decay_active(decay_active));
`default_nettype wire

// ==== sim/rail_fault_pg_mask_regs_tb.sv ====
/*
  Bench for the rail fault and power-good mask bank: byte writes, reads
  and rail stimulus. Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ns
`default_nettype none
module rail_fault_pg_mask_regs_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic [9:0]  lost = 10'h000;
  logic [11:0] pg = 12'hfff;
  logic        slp = 1'b1;
  wire logic [7:0] rdata;
  wire logic [1:0] mode;
  wire logic [1:0] vsel;
  wire logic [9:0] mv;
  wire logic       cpg;
  wire logic       fany;
  wire logic       en;
  wire logic       fpwm;
  wire logic       decay;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [7:0]  ofs [6] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h30, 8'h1a};
  logic [7:0]  rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00};
  logic [9:0]  lv [4] = '{rail_pkg::LEVEL_0_MV, rail_pkg::LEVEL_1_MV,
                          rail_pkg::LEVEL_2_MV, rail_pkg::LEVEL_3_MV};

  rail_fault_pg_mask_regs u_dut (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_en), .reg_rdata(rdata), .regulation_lost(lost),
    .rail_pg(pg), .sleep_state_signal(slp), .combined_power_good(cpg),
    .fault_any(fany), .converter_mode(mode), .converter_enable(en),
    .forced_pwm(fpwm), .output_voltage_select(vsel),
    .output_voltage_mv(mv), .decay_active(decay));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // The strobe is held for exactly one rising edge, as the port expects.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  // Read data is registered, so it is sampled one edge after the address.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk({2'h0, rdata}, {2'h0, e});
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence; inputs move only at falling edges.
  initial begin
    idle(2);
    rst = 1'b0;
    foreach (ofs[i]) rd(ofs[i], rstv[i]);
    chk(10'(mode), 10'h2);
    wr(8'h17, 8'hff);
    rd(8'h17, 8'h00);
    wr(8'h19, 8'hff);
    rd(8'h19, 8'h0f);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h7f);
    wr(8'h19, 8'h00);
    pg = 12'hbf7;
    idle(6);
    chk(10'(cpg), 10'h0);
    wr(8'h18, 8'h08);
    idle(6);
    chk(10'(cpg), 10'h0);
    wr(8'h19, 8'h04);
    idle(6);
    chk(10'(cpg), 10'h1);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h00);
    pg = 12'hfff;
    lost = 10'h201;
    idle(6);
    lost = 10'h000;
    idle(2);
    chk(10'(fany), 10'h1);
    rd(8'h16, 8'h01);
    rd(8'h17, 8'h02);
    idle(4);
    rd(8'h16, 8'h01);
    wr(8'h16, 8'hfe);
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h02);
    wr(8'h17, 8'h00);
    rd(8'h17, 8'h00);
    idle(3);
    chk(10'(fany), 10'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h30, {2'h0, 2'(i), 2'h0, 2'(i)});
      idle(2);
      chk(10'(mode), 10'(i));
      chk(10'(en), 10'(i != 0));
      chk(10'(fpwm), 10'(i == 3));
      chk(10'(vsel), 10'(i));
      chk(mv, lv[i]);
    end
    wr(8'h30, 8'h4d);
    // The converter's own rail sags during decay; the tree must stay good.
    slp = 1'b0;
    pg = 12'hf7f;
    idle(5);
    chk(10'(decay), 10'h1);
    chk(10'(cpg), 10'h1);
    slp = 1'b1;
    idle(6);
    chk(10'(mode), 10'h3);
    chk(10'(decay), 10'h0);
    chk(10'(cpg), 10'h0);
    pg = 12'hfff;
    wr(8'h30, 8'h01);
    slp = 1'b0;
    idle(5);
    chk(10'(decay), 10'h0);
    slp = 1'b1;
    idle(6);
    chk(10'(mode), 10'h1);
    summarize();
  end

  // The tests need about 130 cycles; this bound cuts a hang short.
  initial begin
    #50000;
    n_fail++;
    summarize();
  end
endmodule // rail_fault_pg_mask_regs_tb
`default_nettype wire
